// file: shared/csb_defs.svh
// register map, field positions and opcodes of the compare/skip/adjust block
`ifndef CSB_DEFS_SVH
`define CSB_DEFS_SVH

`define CSB_OFF_CTRL 12'h000
`define CSB_OFF_INSTR 12'h004
`define CSB_OFF_WORKING_REGISTER 12'h008
`define CSB_OFF_STATUS 12'h00C
`define CSB_OFF_BANK 12'h010
`define CSB_OFF_INDEX 12'h014
`define CSB_OFF_MEM_ADDR 12'h018
`define CSB_OFF_MEM_DATA 12'h01C

`define CSB_CTRL_GO 0
`define CSB_CTRL_EXT 1
`define CSB_CTRL_TWO_WORD 2

`define CSB_ST_CARRY 0
`define CSB_ST_DCARRY 1
`define CSB_ST_BUSY 8
`define CSB_ST_SKIPPED 9
`define CSB_ST_ILLEGAL 10
`define CSB_ST_CYC_LSB 16
`define CSB_ST_CYC_MSB 17

`define CSB_OP_GT 7'b0110_010
`define CSB_OP_LT 7'b0110_000
`define CSB_OP_DAW 16'h0007
`define CSB_OP_MSB 15
`define CSB_OP_LSB 9
`define CSB_BANK_BIT 8

`define CSB_INDEXED_MAX 8'h5F
`define CSB_ACCESS_HI_BANK 4'hF
`define CSB_ACCESS_LO_BANK 4'h0
`define CSB_BCD_MAX 5'h09
`define CSB_BCD_FIX 5'h06

`define CSB_ONE_CYCLE 2'h1
`define CSB_TWO_CYCLES 2'h2
`define CSB_THREE_CYCLES 2'h3
`define CSB_PHASE_LAST 2'h3

`endif

// file: shared/csb_pkg.sv
// types shared by the compare/skip/adjust block
package csb_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } csb_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } csb_apb_rsp_t;

  typedef enum logic [1:0] {
    CSB_KIND_NONE,
    CSB_KIND_GT,
    CSB_KIND_LT,
    CSB_KIND_DAW
  } csb_kind_t;

  typedef enum {
    CSB_IDLE,
    CSB_DECODE,
    CSB_READ,
    CSB_PROCESS,
    CSB_WRITE,
    CSB_SKIP
  } csb_state_t;

endpackage

// file: rtl/csb_data_mem.sv
// byte-wide data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module csb_data_mem #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [ADDR_W-1:0] raddr,
  output logic [DATA_W-1:0] rdata_reg
);
  initial
  begin
    if (ADDR_W < 8 || DATA_W < 1)
    begin
      $error("csb_data_mem: ADDR_W must be at least 8");
    end
  end

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge sys_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata_reg <= mem[raddr];
  end
endmodule
`default_nettype wire

// file: rtl/csb_bcd_nibble.sv
// one nibble of decimal correction: add carry-in, then add six when out of range
`timescale 1ns/1ps
`default_nettype none
`include "csb_defs.svh"
module csb_bcd_nibble (
  input wire logic [3:0] val,
  input wire logic add_in,
  input wire logic force_fix,
  output logic [3:0] res,
  output logic carry_out
);
  logic [4:0] sum;
  logic [4:0] fixed;

  always_comb
  begin
    sum = {1'b0, val} + {4'h0, add_in};
    if (sum > `CSB_BCD_MAX || force_fix)
    begin
      fixed = sum + `CSB_BCD_FIX;
    end
    else
    begin
      fixed = sum;
    end
    res = fixed[3:0];
    carry_out = fixed[4];
  end
endmodule
`default_nettype wire

// file: rtl/csb_core.sv
// compare-and-skip and decimal-adjust execution unit with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "csb_defs.svh"

// What this block does
// (RULE1) greater-than compare: 0110 010a opcode byte, 8-bit file address low byte
// (RULE2) skip next instruction when file byte exceeds working register
// (RULE3) less-than compare: 0110 000a opcode byte, 8-bit file address low byte
// (RULE4) skip next instruction when file byte is below working register
// (RULE5) compares use unsigned subtraction, store nothing, touch no flag
// (RULE6) bank bit 0 selects access bank, 1 uses bank select register
// (RULE7) greater-than with bank 0, extended set and address up to 95 is indexed
// (RULE8) one cycle, two when skipping, three when skipping a two-word instruction
// (RULE9) low nibble gets plus six when above nine or decimal carry set
// (RULE10) high nibble plus carry, plus six when above nine or carry; only carry changes; the code adds the decimal carry flag, not the low nibble carry-out
// (RULE11) decimal adjust: one word, one cycle, writes working register back
// (RULE12) each cycle has decode, read, process, write-or-nothing phases
module csb_core
  import csb_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire csb_apb_req_t apb_req,
  output csb_apb_rsp_t apb_rsp
);
  initial
  begin
    if (ADDR_W != 12)
    begin
      $error("csb_core: data space must be 12 bits wide");
    end
  end

  // ************************************
  // register state
  // ************************************
  logic ext_en_reg, ext_en_next;
  logic two_word_reg, two_word_next;
  logic [15:0] instr_reg, instr_next;
  logic [7:0] working_register_reg, working_register_next;
  logic carry_reg, carry_next;
  logic dcarry_reg, dcarry_next;
  logic [3:0] bank_reg, bank_next;
  logic [ADDR_W-1:0] index_reg, index_next;
  logic [ADDR_W-1:0] mem_addr_reg, mem_addr_next;
  logic skipped_reg, skipped_next;
  logic illegal_reg, illegal_next;
  logic [1:0] cycles_reg, cycles_next;
  csb_apb_rsp_t rsp_reg, rsp_next;

  // ************************************
  // execution state
  // ************************************
  csb_state_t state_reg, state_next;
  csb_kind_t kind_reg, kind_next;
  logic [ADDR_W-1:0] eff_addr_reg, eff_addr_next;
  logic [1:0] phase_reg, phase_next;
  logic [1:0] skip_left_reg, skip_left_next;
  logic take_skip_reg, take_skip_next;

  logic busy;
  logic go;
  logic apb_access;
  logic apb_wr;
  logic [7:0] file_byte;
  logic [8:0] diff;
  logic [3:0] lo_res, hi_res;
  logic hi_co;
  logic mem_we;
  logic [ADDR_W-1:0] mem_raddr;
  logic [7:0] fa;
  logic bank_bit;

  assign busy = (state_reg != CSB_IDLE);
  assign apb_access = apb_req.psel && apb_req.penable && !rsp_reg.pready;
  assign apb_wr = apb_access && apb_req.pwrite;
  assign go = apb_wr && (apb_req.paddr == `CSB_OFF_CTRL) && apb_req.pwdata[`CSB_CTRL_GO]
    && !busy;
  assign mem_we = apb_wr && (apb_req.paddr == `CSB_OFF_MEM_DATA) && !busy;
  assign mem_raddr = busy ? eff_addr_reg : mem_addr_reg;
  assign fa = instr_reg[7:0];
  assign bank_bit = instr_reg[`CSB_BANK_BIT];

  csb_data_mem #(
    .ADDR_W(ADDR_W),
    .DATA_W(8)
  ) u_mem (
    .sys_clk(sys_clk),
    .we(mem_we),
    .waddr(mem_addr_reg),
    .wdata(apb_req.pwdata[7:0]),
    .raddr(mem_raddr),
    .rdata_reg(file_byte)
  );

  // low nibble fix, forced by decimal carry
  csb_bcd_nibble u_lo (
    .val(working_register_reg[3:0]),
    .add_in(1'b0),
    .force_fix(dcarry_reg),
    .res(lo_res),
    .carry_out()
  );

  // high nibble takes decimal carry in, fix forced by carry
  csb_bcd_nibble u_hi (
    .val(working_register_reg[7:4]),
    .add_in(dcarry_reg),
    .force_fix(carry_reg),
    .res(hi_res),
    .carry_out(hi_co)
  );

  // unsigned file byte minus working register; bit 8 is the borrow
  assign diff = {1'b0, file_byte} - {1'b0, working_register_reg}; // [RULE5]

  // ************************************
  // sequencer and register writes
  // ************************************
  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    eff_addr_next = eff_addr_reg;
    phase_next = phase_reg;
    skip_left_next = skip_left_reg;
    take_skip_next = take_skip_reg;
    ext_en_next = ext_en_reg;
    two_word_next = two_word_reg;
    instr_next = instr_reg;
    working_register_next = working_register_reg;
    carry_next = carry_reg;
    dcarry_next = dcarry_reg;
    bank_next = bank_reg;
    index_next = index_reg;
    mem_addr_next = mem_addr_reg;
    skipped_next = skipped_reg;
    illegal_next = illegal_reg;
    cycles_next = cycles_reg;

    if (apb_wr && !busy)
    begin
      case (apb_req.paddr)
        `CSB_OFF_CTRL:
        begin
          ext_en_next = apb_req.pwdata[`CSB_CTRL_EXT];
          two_word_next = apb_req.pwdata[`CSB_CTRL_TWO_WORD];
        end
        `CSB_OFF_INSTR: instr_next = apb_req.pwdata[15:0];
        `CSB_OFF_WORKING_REGISTER: working_register_next = apb_req.pwdata[7:0];
        `CSB_OFF_STATUS:
        begin
          carry_next = apb_req.pwdata[`CSB_ST_CARRY];
          dcarry_next = apb_req.pwdata[`CSB_ST_DCARRY];
        end
        `CSB_OFF_BANK: bank_next = apb_req.pwdata[3:0];
        `CSB_OFF_INDEX: index_next = apb_req.pwdata[ADDR_W-1:0];
        `CSB_OFF_MEM_ADDR: mem_addr_next = apb_req.pwdata[ADDR_W-1:0];
        default:
        begin
        end
      endcase
    end

    case (state_reg)
      CSB_IDLE:
      begin
        if (go)
        begin
          state_next = CSB_DECODE;
          skipped_next = 1'b0;
          illegal_next = 1'b0;
          take_skip_next = 1'b0;
        end
      end
      CSB_DECODE:
      begin
        // opcode classification in the first phase
        if (instr_reg[`CSB_OP_MSB:`CSB_OP_LSB] == `CSB_OP_GT) // [RULE1] [RULE12]
        begin
          kind_next = CSB_KIND_GT;
        end
        else if (instr_reg[`CSB_OP_MSB:`CSB_OP_LSB] == `CSB_OP_LT) // [RULE3]
        begin
          kind_next = CSB_KIND_LT;
        end
        else if (instr_reg == `CSB_OP_DAW) // [RULE11]
        begin
          kind_next = CSB_KIND_DAW;
        end
        else
        begin
          kind_next = CSB_KIND_NONE;
          illegal_next = 1'b1;
        end
        // operand address
        if (bank_bit)
        begin
          eff_addr_next = {bank_reg, fa}; // [RULE6]
        end
        else if (ext_en_reg && fa <= `CSB_INDEXED_MAX
          && instr_reg[`CSB_OP_MSB:`CSB_OP_LSB] == `CSB_OP_GT)
        begin
          eff_addr_next = index_reg + {4'h0, fa}; // [RULE7]
        end
        else if (fa[7])
        begin
          eff_addr_next = {`CSB_ACCESS_HI_BANK, fa}; // [RULE6]
        end
        else
        begin
          eff_addr_next = {`CSB_ACCESS_LO_BANK, fa};
        end
        state_next = CSB_READ;
      end
      CSB_READ:
      begin
        // file byte is registered out of memory during this phase
        state_next = CSB_PROCESS; // [RULE12]
      end
      CSB_PROCESS:
      begin
        case (kind_reg)
          CSB_KIND_GT: take_skip_next = !diff[8] && (diff[7:0] != 8'h00); // [RULE2]
          CSB_KIND_LT: take_skip_next = diff[8]; // [RULE4]
          default: take_skip_next = 1'b0;
        endcase
        state_next = CSB_WRITE;
      end
      CSB_WRITE:
      begin
        if (kind_reg == CSB_KIND_DAW)
        begin
          working_register_next = {hi_res, lo_res}; // [RULE9] [RULE10] [RULE11]
          carry_next = carry_reg | hi_co; // [RULE10]
        end
        if (take_skip_reg)
        begin
          // fetched word becomes no-operation cycles
          skipped_next = 1'b1; // [RULE2] [RULE4]
          skip_left_next = two_word_reg ? `CSB_TWO_CYCLES : `CSB_ONE_CYCLE; // [RULE8]
          cycles_next = two_word_reg ? `CSB_THREE_CYCLES : `CSB_TWO_CYCLES; // [RULE8]
          phase_next = 2'h0;
          state_next = CSB_SKIP;
        end
        else
        begin
          cycles_next = `CSB_ONE_CYCLE; // [RULE8]
          state_next = CSB_IDLE;
        end
      end
      CSB_SKIP:
      begin
        // four idle phases per discarded cycle
        phase_next = phase_reg + 2'h1; // [RULE8] [RULE12]
        if (phase_reg == `CSB_PHASE_LAST)
        begin
          skip_left_next = skip_left_reg - 2'h1;
          if (skip_left_reg == `CSB_ONE_CYCLE)
          begin
            state_next = CSB_IDLE;
          end
        end
      end
      default: state_next = CSB_IDLE;
    endcase
  end

  // ************************************
  // apb answer, one wait state
  // ************************************
  always_comb
  begin
    rsp_next.pready = apb_access;
    rsp_next.pslverr = 1'b0;
    rsp_next.prdata = 32'h0000_0000;
    if (apb_access && !apb_req.pwrite)
    begin
      case (apb_req.paddr)
        `CSB_OFF_CTRL:
        begin
          rsp_next.prdata[`CSB_CTRL_EXT] = ext_en_reg;
          rsp_next.prdata[`CSB_CTRL_TWO_WORD] = two_word_reg;
        end
        `CSB_OFF_INSTR: rsp_next.prdata[15:0] = instr_reg;
        `CSB_OFF_WORKING_REGISTER: rsp_next.prdata[7:0] = working_register_reg;
        `CSB_OFF_STATUS:
        begin
          rsp_next.prdata[`CSB_ST_CARRY] = carry_reg;
          rsp_next.prdata[`CSB_ST_DCARRY] = dcarry_reg;
          rsp_next.prdata[`CSB_ST_BUSY] = busy;
          rsp_next.prdata[`CSB_ST_SKIPPED] = skipped_reg;
          rsp_next.prdata[`CSB_ST_ILLEGAL] = illegal_reg;
          rsp_next.prdata[`CSB_ST_CYC_MSB:`CSB_ST_CYC_LSB] = cycles_reg;
        end
        `CSB_OFF_BANK: rsp_next.prdata[3:0] = bank_reg;
        `CSB_OFF_INDEX: rsp_next.prdata[ADDR_W-1:0] = index_reg;
        `CSB_OFF_MEM_ADDR: rsp_next.prdata[ADDR_W-1:0] = mem_addr_reg;
        `CSB_OFF_MEM_DATA: rsp_next.prdata[7:0] = file_byte;
        default: rsp_next.pslverr = 1'b1;
      endcase
    end
    else if (apb_access)
    begin
      case (apb_req.paddr)
        `CSB_OFF_CTRL, `CSB_OFF_INSTR, `CSB_OFF_WORKING_REGISTER, `CSB_OFF_STATUS,
        `CSB_OFF_BANK, `CSB_OFF_INDEX, `CSB_OFF_MEM_ADDR, `CSB_OFF_MEM_DATA:
          rsp_next.pslverr = 1'b0;
        default: rsp_next.pslverr = 1'b1;
      endcase
    end
  end

  // ************************************
  // registers
  // ************************************
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= CSB_IDLE;
      kind_reg <= CSB_KIND_NONE;
      eff_addr_reg <= '0;
      phase_reg <= 2'h0;
      skip_left_reg <= 2'h0;
      take_skip_reg <= 1'b0;
      ext_en_reg <= 1'b0;
      two_word_reg <= 1'b0;
      instr_reg <= 16'h0000;
      working_register_reg <= 8'h00;
      carry_reg <= 1'b0;
      dcarry_reg <= 1'b0;
      bank_reg <= 4'h0;
      index_reg <= '0;
      mem_addr_reg <= '0;
      skipped_reg <= 1'b0;
      illegal_reg <= 1'b0;
      cycles_reg <= 2'h0;
      rsp_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      eff_addr_reg <= eff_addr_next;
      phase_reg <= phase_next;
      skip_left_reg <= skip_left_next;
      take_skip_reg <= take_skip_next;
      ext_en_reg <= ext_en_next;
      two_word_reg <= two_word_next;
      instr_reg <= instr_next;
      working_register_reg <= working_register_next;
      carry_reg <= carry_next;
      dcarry_reg <= dcarry_next;
      bank_reg <= bank_next;
      index_reg <= index_next;
      mem_addr_reg <= mem_addr_next;
      skipped_reg <= skipped_next;
      illegal_reg <= illegal_next;
      cycles_reg <= cycles_next;
      rsp_reg <= rsp_next;
    end
  end

  assign apb_rsp = rsp_reg;
endmodule
`default_nettype wire

// file: tb/csb_core_assertions.sv
// checker of the apb answer and result status of the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "csb_defs.svh"
module csb_core_assertions
  import csb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire csb_apb_req_t apb_req,
  input wire csb_apb_rsp_t apb_rsp
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  logic st_rd;
  logic [1:0] cyc;
  assign st_rd = apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == `CSB_OFF_STATUS;
  assign cyc = apb_rsp.prdata[17:16];
  property p_one_wait;
    apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
  property p_pulse;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_cause;
    $rose(apb_rsp.pready) |-> $past(apb_req.psel && apb_req.penable);
  endproperty
  a_cause: assert property (p_cause) else $error("ready without access phase");
  property p_quiet;
    !apb_rsp.pready |-> apb_rsp.prdata == 32'h0000_0000 && !apb_rsp.pslverr;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer lines not quiet");
  property p_unmapped;
    apb_rsp.pready && apb_req.paddr > `CSB_OFF_MEM_DATA |-> apb_rsp.pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped;
    apb_rsp.pready && apb_req.paddr <= `CSB_OFF_MEM_DATA && apb_req.paddr[1:0] == 2'h0
      |-> !apb_rsp.pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_skip_cycles;
    st_rd && !apb_rsp.prdata[8] && apb_rsp.prdata[9] |-> cyc == 2'h2 || cyc == 2'h3;
  endproperty
  a_skip_cycles: assert property (p_skip_cycles) else $error("skip cycle count wrong");
  property p_plain_cycles;
    st_rd && apb_rsp.prdata[10:8] == 3'h0 && cyc != 2'h0 |-> cyc == 2'h1;
  endproperty
  a_plain_cycles: assert property (p_plain_cycles) else $error("cycle count wrong");
  property p_working_register_narrow;
    apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == `CSB_OFF_WORKING_REGISTER
      |-> apb_rsp.prdata[31:8] == 24'h00_0000;
  endproperty
  a_working_register_narrow: assert property (p_working_register_narrow) else $error("wide working value");
  c_skip: cover property (st_rd && apb_rsp.prdata[9]);
  c_three: cover property (st_rd && cyc == 2'h3);
  c_err: cover property (apb_rsp.pslverr);
endmodule
bind csb_core csb_core_assertions u_csb_core_assertions (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp)
);
`default_nettype wire

// file: tb/csb_core_bench.sv
// self-checking bench of the execution unit over apb
`timescale 1ns/1ps
`default_nettype none
`include "csb_defs.svh"
`define CSB_CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module csb_core_bench
  import csb_pkg::*;
;
  // ****
  // stimulus and checks
  // ****
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  csb_apb_req_t apb_req = '0;
  csb_apb_rsp_t apb_rsp;
  int errors = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic err;
  always #20 sys_clk = ~sys_clk;
  csb_core u_csb_core (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp)
  );
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang(input int n, input int lim);
    if (n >= lim)
    begin
      errors++;
      $display("ERROR %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  // one transfer: setup, access, hold until ready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 20);
    hang(n, 20);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic poke(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, `CSB_OFF_MEM_ADDR, {20'h0_0000, a});
    apb(1'b1, `CSB_OFF_MEM_DATA, {24'h00_0000, d});
  endtask
  // ctl is {two word, extended}; exp_st is {cycles, illegal, skipped, dc, c}
  task automatic exec(input logic [15:0] ins, input logic [7:0] w, input logic [1:0] fl,
                      input logic [1:0] ctl, input logic [7:0] exp_w, input logic [5:0] exp_st);
    int n;
    apb(1'b1, `CSB_OFF_INSTR, {16'h0000, ins});
    apb(1'b1, `CSB_OFF_WORKING_REGISTER, {24'h00_0000, w});
    apb(1'b1, `CSB_OFF_STATUS, {30'h0000_0000, fl});
    apb(1'b1, `CSB_OFF_CTRL, {29'h0000_0000, ctl, 1'b1});
    n = 0;
    do
    begin
      apb(1'b0, `CSB_OFF_STATUS, 32'h0000_0000);
      n++;
    end
    while (rd[`CSB_ST_BUSY] !== 1'b0 && n < 50);
    hang(n, 50);
    `CSB_CHK({rd[17:16], rd[10:9], rd[1:0]}, exp_st)
    apb(1'b0, `CSB_OFF_WORKING_REGISTER, 32'h0000_0000);
    `CSB_CHK(rd, {24'h00_0000, exp_w})
  endtask
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    hang(1, 1);
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, `CSB_OFF_STATUS, 32'h0000_0000);
    `CSB_CHK(rd, 32'h0000_0000)
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CSB_CHK(err, 1'b1)
    apb(1'b1, `CSB_OFF_BANK, 32'h0000_0003);
    apb(1'b1, `CSB_OFF_INDEX, 32'h0000_0200);
    poke(12'h345, 8'h80);
    poke(12'h010, 8'h01);
    poke(12'hF90, 8'h50);
    poke(12'h390, 8'h30);
    poke(12'h090, 8'h30);
    poke(12'h220, 8'h09);
    poke(12'h020, 8'h00);
    poke(12'h25F, 8'h09);
    poke(12'h05F, 8'h00);
    poke(12'h060, 8'h09);
    poke(12'h260, 8'h00);
    exec(16'h6545, 8'h7F, 2'h0, 2'h0, 8'h7F, 6'h24);
    exec(16'h6545, 8'h80, 2'h0, 2'h0, 8'h80, 6'h10);
    exec(16'h6145, 8'h81, 2'h0, 2'h0, 8'h81, 6'h24);
    exec(16'h6145, 8'h80, 2'h3, 2'h0, 8'h80, 6'h13);
    exec(16'h6010, 8'hFF, 2'h3, 2'h2, 8'hFF, 6'h37);
    exec(16'h6090, 8'h40, 2'h0, 2'h0, 8'h40, 6'h10);
    exec(16'h6420, 8'h05, 2'h0, 2'h1, 8'h05, 6'h24);
    exec(16'h645F, 8'h05, 2'h0, 2'h1, 8'h05, 6'h24);
    exec(16'h6460, 8'h05, 2'h0, 2'h1, 8'h05, 6'h24);
    exec(16'h6020, 8'h05, 2'h0, 2'h1, 8'h05, 6'h24);
    exec(16'h6420, 8'h05, 2'h0, 2'h0, 8'h05, 6'h10);
    exec(16'h0007, 8'hA5, 2'h0, 2'h0, 8'h05, 6'h11);
    exec(16'h0007, 8'h23, 2'h2, 2'h0, 8'h39, 6'h12);
    exec(16'h0007, 8'h32, 2'h1, 2'h0, 8'h92, 6'h11);
    exec(16'h0007, 8'h45, 2'h0, 2'h0, 8'h45, 6'h10);
    exec(16'hFFFF, 8'h12, 2'h0, 2'h0, 8'h12, 6'h18);
    apb(1'b1, `CSB_OFF_MEM_ADDR, 32'h0000_0345);
    apb(1'b0, `CSB_OFF_MEM_DATA, 32'h0000_0000);
    `CSB_CHK(rd, 32'h0000_0080)
    // reset in mid-run clears the working value
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, `CSB_OFF_WORKING_REGISTER, 32'h0000_0000);
    `CSB_CHK(rd, 32'h0000_0000)
    give_verdict();
  end
endmodule
`default_nettype wire
